// File: src/dtc_pkg.sv
// Purpose: constants for the dual timer/counter block
// Assumes: 10 MHz system clock, classic Wishbone register access
// Notes: register layout and mode field positions live here
package dtc_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] DTC_A_LOW_OFS = 8'h00;
  localparam logic [7:0] DTC_A_HIGH_OFS = 8'h04;
  localparam logic [7:0] DTC_B_LOW_OFS = 8'h08;
  localparam logic [7:0] DTC_B_HIGH_OFS = 8'h0C;
  localparam logic [7:0] DTC_MODE_OFS = 8'h10;
  localparam logic [7:0] DTC_RUN_OFS = 8'h14;
  localparam logic [7:0] DTC_STATUS_OFS = 8'h18;
  localparam logic [7:0] DTC_CLEAR_OFS = 8'h1C;
  localparam logic [7:0] DTC_ENABLE_OFS = 8'h20;
  localparam int DTC_ADDR_W = 8;
  // ----------------------------------------------------------------
  // per-timer mode nibble: [1:0] mode, [2] counter, [3] gate
  // mode 2 is 8-bit reload, mode 3 is 16-bit on the short divider,
  // anything else is 16-bit on the long divider
  // timer a nibble at bits 3:0, timer b at bits 7:4
  // ----------------------------------------------------------------
  localparam int DTC_MODE_LSB = 0;
  localparam int DTC_CNT_BIT = 2;
  localparam int DTC_GATE_BIT = 3;
  localparam int DTC_NIB_W = 4;
  localparam logic [1:0] DTC_MODE_FAST = 2'h3;
  localparam logic [7:0] DTC_MODE_RST = 8'h00;
  localparam logic [1:0] DTC_MODE_16 = 2'h1;
  localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
  localparam logic [7:0] DTC_BYTE_MAX = 8'hFF;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DTC_SLOW_DIV = 12;
  localparam int DTC_FAST_DIV = 4;
  localparam logic [3:0] DTC_SLOW_LAST = 4'(DTC_SLOW_DIV - 1);
  localparam logic [3:0] DTC_FAST_LAST = 4'(DTC_FAST_DIV - 1);
  localparam int DTC_TIMERS = 2;
endpackage

// File: src/dtc_prescale.sv
// Purpose: clock-period divider producing a one-cycle tick
// Assumes: runs from the system clock only
// Notes: fast selects the short period
`timescale 1ns/10ps
`default_nettype none
module dtc_prescale
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic fast_i,
  output logic tick_o
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  wire [3:0] last_w = fast_i ? DTC_FAST_LAST : DTC_SLOW_LAST;
  wire wrap_w = (cnt_reg >= last_w);
  assign cnt_next = wrap_w ? 4'h0 : cnt_reg + 4'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o <= wrap_w;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // helper state: cycles since the last tick, and whether the divider
  // choice moved since then (a moved choice makes one gap irregular)
  logic [3:0] gap_reg;
  logic fast_seen_reg;
  logic mixed_reg;
  logic ticked_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_reg <= 4'h0;
      fast_seen_reg <= 1'b0;
      mixed_reg <= 1'b0;
      ticked_reg <= 1'b0;
    end else if (tick_o) begin
      gap_reg <= 4'h1;
      fast_seen_reg <= fast_i;
      mixed_reg <= 1'b0;
      ticked_reg <= 1'b1;
    end else begin
      gap_reg <= (gap_reg == 4'hF) ? gap_reg : gap_reg + 4'h1;
      mixed_reg <= mixed_reg | (fast_i != fast_seen_reg);
    end
  end
  chk_tick_slow_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    (ticked_reg && !mixed_reg && !fast_seen_reg && (gap_reg <= 4'(DTC_SLOW_DIV)))
    |-> (tick_o == (gap_reg == 4'(DTC_SLOW_DIV))))
    else $error("slow tick spacing wrong");
  chk_tick_fast_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    (ticked_reg && !mixed_reg && fast_seen_reg && (gap_reg <= 4'(DTC_FAST_DIV)))
    |-> (tick_o == (gap_reg == 4'(DTC_FAST_DIV))))
    else $error("fast tick spacing wrong");
endmodule
`default_nettype wire

// File: src/dtc_unit.sv
// Purpose: one 16-bit timer/counter with byte load and auto-reload
// Assumes: inputs synchronous to clk_i; load has priority over counting
// Notes: overflow is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module dtc_unit
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic [DTC_NIB_W-1:0] mode_i,
  input wire logic run_i,
  input wire logic tick_i,
  // pins
  input wire logic count_in_i,
  input wire logic gate_in_i,
  // software load
  input wire logic wr_low_i,
  input wire logic wr_high_i,
  input wire logic [7:0] wdata_i,
  // state
  output logic [7:0] low_o,
  output logic [7:0] high_o,
  output logic ovf_o
);
  logic samp_reg;
  logic prev_reg;
  wire [1:0] mode_w = mode_i[DTC_MODE_LSB +: 2];
  wire is_counter_w = mode_i[DTC_CNT_BIT];
  wire gated_w = mode_i[DTC_GATE_BIT];
  wire fall_w = prev_reg & ~samp_reg;
  wire open_w = run_i & (~gated_w | gate_in_i);
  wire step_w = open_w & (is_counter_w ? fall_w : tick_i);
  wire reload_w = (mode_w == DTC_MODE_RELOAD);
  wire low_full_w = (low_o == DTC_BYTE_MAX);
  wire all_full_w = low_full_w & (high_o == DTC_BYTE_MAX);
  wire wrap_w = step_w & (reload_w ? low_full_w : all_full_w);
  wire [15:0] inc_w = {high_o, low_o} + 16'h0001;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      samp_reg <= count_in_i;
      prev_reg <= samp_reg;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_o <= 8'h00;
      high_o <= 8'h00;
      ovf_o <= 1'b0;
    end else begin
      ovf_o <= wrap_w;
      if (wr_high_i) begin
        high_o <= wdata_i;
      end else if (step_w && !reload_w) begin
        high_o <= inc_w[15:8];
      end
      if (wr_low_i) begin
        low_o <= wdata_i;
      end else if (step_w && reload_w && low_full_w) begin
        low_o <= high_o;
      end else if (step_w) begin
        low_o <= inc_w[7:0];
      end
    end
  end
  chk_reload_value: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap_w && reload_w && !wr_low_i && !wr_high_i) |=> (low_o == $past(high_o)) && ovf_o)
    else $error("auto-reload value wrong");
  chk_fall_counts: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_counter_w && open_w && fall_w && !reload_w && !wr_low_i && !wr_high_i)
    |=> {high_o, low_o} == $past(inc_w))
    else $error("falling edge not counted");
  chk_shut_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (gated_w && !gate_in_i && !wr_low_i && !wr_high_i) |=> $stable({high_o, low_o}))
    else $error("closed gate still counts");
  chk_edge_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(count_in_i, 2) && !$past(count_in_i)) |-> fall_w)
    else $error("edge detect timing wrong");
endmodule
`default_nettype wire

// File: src/dtc_top.sv
// Purpose: dual 16-bit timer/counter with Wishbone register access
// Assumes: classic Wishbone, 8-bit data in the low lane of 32 bits
// Notes: ack one cycle after request; irq is level
`timescale 1ns/10ps
`default_nettype none
module dtc_top
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DTC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // count and gate pins
  input wire logic timer_a_count_input_i,
  input wire logic timer_b_count_input_i,
  input wire logic timer_a_gate_input_i,
  input wire logic timer_b_gate_input_i,
  // events
  output logic baud_tick_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] timer_mode_select_reg;
  logic [1:0] run_reg;
  logic [1:0] status_reg;
  logic [1:0] enable_reg;
  logic [1:0] status_next;
  logic [7:0] timer_a_low_byte;
  logic [7:0] timer_a_high_byte;
  logic [7:0] timer_b_low_byte;
  logic [7:0] timer_b_high_byte;
  logic ovf_a;
  logic ovf_b;
  logic tick_a;
  logic tick_b;
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_w = req_w & wb_we_i & wb_sel_i[0];
  wire [7:0] wd_w = wb_dat_i[7:0];
  wire sel_al_w = (wb_adr_i == DTC_A_LOW_OFS);
  wire sel_ah_w = (wb_adr_i == DTC_A_HIGH_OFS);
  wire sel_bl_w = (wb_adr_i == DTC_B_LOW_OFS);
  wire sel_bh_w = (wb_adr_i == DTC_B_HIGH_OFS);
  wire sel_md_w = (wb_adr_i == DTC_MODE_OFS);
  wire sel_rn_w = (wb_adr_i == DTC_RUN_OFS);
  wire sel_st_w = (wb_adr_i == DTC_STATUS_OFS);
  wire sel_cl_w = (wb_adr_i == DTC_CLEAR_OFS);
  wire sel_en_w = (wb_adr_i == DTC_ENABLE_OFS);
  wire [3:0] nib_a_w = timer_mode_select_reg[DTC_NIB_W-1:0];
  wire [3:0] nib_b_w = timer_mode_select_reg[2*DTC_NIB_W-1:DTC_NIB_W];
  wire fast_a_w = (nib_a_w[DTC_MODE_LSB +: 2] == DTC_MODE_FAST);
  wire fast_b_w = (nib_b_w[DTC_MODE_LSB +: 2] == DTC_MODE_FAST);
  wire [1:0] clr_w = (wr_w && sel_cl_w) ? wd_w[1:0] : 2'h0;
  wire [7:0] rd_w =
    sel_al_w ? timer_a_low_byte :
    sel_ah_w ? timer_a_high_byte :
    sel_bl_w ? timer_b_low_byte :
    sel_bh_w ? timer_b_high_byte :
    sel_md_w ? timer_mode_select_reg :
    sel_rn_w ? {6'h00, run_reg} :
    sel_st_w ? {6'h00, status_reg} :
    sel_en_w ? {6'h00, enable_reg} : 8'h00;
  // set wins over clear
  assign status_next = (status_reg & ~clr_w) | {ovf_b, ovf_a};
  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  dtc_prescale u_pre_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fast_i(fast_a_w),
    .tick_o(tick_a)
  );
  dtc_prescale u_pre_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fast_i(fast_b_w),
    .tick_o(tick_b)
  );
  // mode 3 picks the short divider; counter mode ignores the tick, so the
  // divider choice only matters while bit 2 selects timer operation
  dtc_unit u_timer_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_i(nib_a_w),
    .run_i(run_reg[0]),
    .tick_i(tick_a),
    .count_in_i(timer_a_count_input_i),
    .gate_in_i(timer_a_gate_input_i),
    .wr_low_i(wr_w & sel_al_w),
    .wr_high_i(wr_w & sel_ah_w),
    .wdata_i(wd_w),
    .low_o(timer_a_low_byte),
    .high_o(timer_a_high_byte),
    .ovf_o(ovf_a)
  );
  dtc_unit u_timer_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_i(nib_b_w),
    .run_i(run_reg[1]),
    .tick_i(tick_b),
    .count_in_i(timer_b_count_input_i),
    .gate_in_i(timer_b_gate_input_i),
    .wr_low_i(wr_w & sel_bl_w),
    .wr_high_i(wr_w & sel_bh_w),
    .wdata_i(wd_w),
    .low_o(timer_b_low_byte),
    .high_o(timer_b_high_byte),
    .ovf_o(ovf_b)
  );
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_mode_select_reg <= DTC_MODE_RST;
      run_reg <= 2'h0;
      enable_reg <= 2'h0;
      status_reg <= 2'h0;
    end else begin
      if (wr_w && sel_md_w) begin
        timer_mode_select_reg <= wd_w;
      end
      if (wr_w && sel_rn_w) begin
        run_reg <= wd_w[1:0];
      end
      if (wr_w && sel_en_w) begin
        enable_reg <= wd_w[1:0];
      end
      status_reg <= status_next;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
      baud_tick_o <= 1'b0;
    end else begin
      wb_ack_o <= req_w;
      wb_dat_o <= {24'h00_0000, rd_w};
      irq_o <= |(status_next & enable_reg);
      baud_tick_o <= ovf_b;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ovf_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_a |=> status_reg[0])
    else $error("overflow flag not set");
  chk_flag_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (status_reg[0] && !clr_w[0]) |=> status_reg[0])
    else $error("overflow flag dropped without clear");
  chk_baud_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_b |=> baud_tick_o)
    else $error("baud tick missing");
  chk_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (!run_reg[0] && !(wr_w && (sel_al_w || sel_ah_w))) |=>
    $stable({timer_a_high_byte, timer_a_low_byte}))
    else $error("stopped timer moved");
endmodule
`default_nettype wire

// File: sim/dtc_pins_model.sv
// Purpose: far-side pin driver for the timer block: count and gate pins
// Assumes: pins change just after a rising clock edge
// Notes: count pins idle high; noise_i scrambles pin a to probe timer mode
`timescale 1ns/10ps
`default_nettype none
module dtc_pins_model (
  // clock and control
  input wire logic clk_i,
  input wire logic noise_i,
  // pins
  output logic [1:0] cnt_o,
  output logic [1:0] gate_o
);
  integer seed = 32'hC6907D28;
  initial begin
    cnt_o = 2'h3;
    gate_o = 2'h0;
  end
  // widths down to one cycle: a slow sampler would miss the short ones
  task automatic fall(input bit b, input int n);
    repeat (n) begin
      @(posedge clk_i);
      cnt_o[b] <= 1'b0;
      repeat ($unsigned($random(seed)) % 3) @(posedge clk_i);
      @(posedge clk_i);
      cnt_o[b] <= 1'b1;
      repeat ($unsigned($random(seed)) % 3) @(posedge clk_i);
    end
  endtask
  task automatic set_gate(input logic [1:0] g);
    @(posedge clk_i);
    gate_o <= g;
  endtask
  // back to idle high once noise stops, so no stray fall follows
  always @(posedge clk_i) begin
    if (noise_i) begin
      cnt_o[0] <= 1'($random(seed));
    end else if ($fell(noise_i)) begin
      cnt_o[0] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: sim/dual_timer_counter_bench.sv
// Purpose: self-checking bench for the dual timer/counter
// Assumes: one-cycle Wishbone ack; a pin step lands within four clocks
// Notes: expected counts come from a step-by-step integer model
`timescale 1ns/10ps
`default_nettype none
module dual_timer_counter_bench;
  import dtc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic noise = 1'b0;
  logic [3:0] sel = 4'h1;
  logic [DTC_ADDR_W-1:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o;
  logic baud_tick_o;
  logic irq_o;
  logic [1:0] cnt;
  logic [1:0] gate;
  int bad_count = 0;
  int check_count = 0;
  int cyc_n = 0;
  int baud_n = 0;
  int ovf_n = 0;
  int v;
  int x0;
  always #50 clk_i = ~clk_i;
  dtc_top dtc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(sel), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_a_count_input_i(cnt[0]),
    .timer_b_count_input_i(cnt[1]), .timer_a_gate_input_i(gate[0]),
    .timer_b_gate_input_i(gate[1]), .baud_tick_o(baud_tick_o), .irq_o(irq_o));
  dtc_pins_model dtc_pins_model_i (.clk_i(clk_i), .noise_i(noise), .cnt_o(cnt), .gate_o(gate));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (baud_tick_o === 1'b1) baud_n <= baud_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    cmp(rd, exp);
  endtask
  // one count step: 8-bit reload keeps the high byte, 16-bit wraps to zero
  function automatic int step(int c, bit rl);
    if (rl && c[7:0] == 8'hFF) begin
      ovf_n++;
      return {c[15:8], c[15:8]};
    end
    if (!rl && c[15:0] == 16'hFFFF) ovf_n++;
    return rl ? {c[15:8], 8'(c[7:0] + 1)} : (c + 1) & 16'hFFFF;
  endfunction
  task automatic pulses(input bit b, input int n, input bit rl, input bit open);
    dtc_pins_model_i.fall(b, n);
    if (open) repeat (n) v = step(v, rl);
    repeat (4) @(posedge clk_i);
    rdc(b ? DTC_B_LOW_OFS : DTC_A_LOW_OFS, 32'(v[7:0]));
    rdc(b ? DTC_B_HIGH_OFS : DTC_A_HIGH_OFS, 32'(v[15:8]));
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 8'h24; a += 4) rdc(8'(a), 32'h0);
    bus(1'b1, 8'h24, 32'hFF);
    rdc(8'h24, 32'h0);
    bus(1'b1, DTC_A_HIGH_OFS, 32'hA5);
    rdc(DTC_A_HIGH_OFS, 32'hA5);
    // a write without its byte lane selected must be dropped
    sel <= 4'h0;
    bus(1'b1, DTC_A_HIGH_OFS, 32'h5A);
    sel <= 4'h1;
    rdc(DTC_A_HIGH_OFS, 32'hA5);
    // timer a on the slow divider while its pin toggles at random
    bus(1'b1, DTC_MODE_OFS, 32'h01);
    bus(1'b1, DTC_RUN_OFS, 32'h1);
    noise <= 1'b1;
    bus(1'b0, DTC_A_LOW_OFS, 32'h0);
    x0 = rd;
    repeat (DTC_SLOW_DIV * 10 - 3) @(posedge clk_i);
    rdc(DTC_A_LOW_OFS, 32'((x0 + 10) & 8'hFF));
    rdc(DTC_B_LOW_OFS, 32'h0);
    noise <= 1'b0;
    // counter a, gated: nothing counts until the gate opens
    bus(1'b1, DTC_MODE_OFS, 32'h0D);
    bus(1'b1, DTC_A_LOW_OFS, 32'h0);
    bus(1'b1, DTC_A_HIGH_OFS, 32'h0);
    v = 0;
    pulses(0, 5, 0, 0);
    dtc_pins_model_i.set_gate(2'h1);
    pulses(0, 7, 0, 1);
    // counter b with auto-reload across one wrap
    bus(1'b1, DTC_MODE_OFS, 32'h6D);
    rdc(DTC_MODE_OFS, 32'h6D);
    bus(1'b1, DTC_B_HIGH_OFS, 32'hF0);
    bus(1'b1, DTC_B_LOW_OFS, 32'hF0);
    bus(1'b1, DTC_RUN_OFS, 32'h3);
    v = 16'hF0F0;
    ovf_n = 0;
    pulses(1, 20, 1, 1);
    rdc(DTC_STATUS_OFS, 32'h2);
    cmp(32'(baud_n), 32'(ovf_n));
    cmp(32'(irq_o), 32'h0);
    bus(1'b1, DTC_ENABLE_OFS, 32'h2);
    repeat (2) @(posedge clk_i);
    cmp(32'(irq_o), 32'h1);
    bus(1'b1, DTC_CLEAR_OFS, 32'h2);
    repeat (2) @(posedge clk_i);
    cmp(32'(irq_o), 32'h0);
    rdc(DTC_STATUS_OFS, 32'h0);
    // full 16-bit wrap of b
    bus(1'b1, DTC_MODE_OFS, 32'h5D);
    bus(1'b1, DTC_B_LOW_OFS, 32'hFE);
    bus(1'b1, DTC_B_HIGH_OFS, 32'hFF);
    v = 16'hFFFE;
    pulses(1, 3, 0, 1);
    rdc(DTC_STATUS_OFS, 32'h2);
    cmp(32'(irq_o), 32'h1);
    cmp(32'(baud_n), 32'(ovf_n));
    // timer a on the short divider runs through its 16-bit wrap
    bus(1'b1, DTC_MODE_OFS, 32'h53);
    bus(1'b1, DTC_A_HIGH_OFS, 32'hFF);
    bus(1'b1, DTC_A_LOW_OFS, 32'hF8);
    bus(1'b0, DTC_A_LOW_OFS, 32'h0);
    x0 = rd;
    repeat (DTC_FAST_DIV * 10 - 3) @(posedge clk_i);
    rdc(DTC_A_LOW_OFS, 32'((x0 + 10) & 8'hFF));
    rdc(DTC_A_HIGH_OFS, 32'h0);
    rdc(DTC_STATUS_OFS, 32'h3);
    wrap_up();
  end
endmodule
`default_nettype wire
